// [core/tcc_pkg.sv]
// constants and types shared by the timer capture/compare block
package tcc_pkg;
	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_MAIN_CTL = 8'h20;
	localparam logic [7:0] IDX_CNT_HI = 8'h21;
	localparam logic [7:0] IDX_CNT_LO = 8'h22;
	localparam logic [7:0] IDX_MOD_HI = 8'h23;
	localparam logic [7:0] IDX_MOD_LO = 8'h24;
	localparam logic [7:0] IDX_T1C0_CTL = 8'h25;
	localparam logic [7:0] IDX_CH0_HI = 8'h26;
	localparam logic [7:0] IDX_CH0_LO = 8'h27;
	localparam logic [7:0] IDX_T1C1_CTL = 8'h28;
	localparam logic [7:0] IDX_CH1_HI = 8'h29;
	localparam logic [7:0] IDX_CH1_LO = 8'h2a;
	// second timer's channel control; not decoded by this instance
	localparam logic [7:0] IDX_T2C0_CTL = 8'h30;
	localparam logic [7:0] IDX_NONE = 8'hff;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 9;

	// channel control bit positions
	localparam int B_FLAG = 7;
	localparam int B_IE = 6;
	localparam int B_MSB = 5;
	localparam int B_MSA = 4;
	localparam int B_ELSH = 3;
	localparam int B_ELSL = 2;
	localparam int B_TOV = 1;
	localparam int B_MAX = 0;

	// main control bit positions, prescale select in [2:0]
	localparam int M_OVF = 7;
	localparam int M_OIE = 6;
	localparam int M_STOP = 5;
	localparam int M_RST = 4;
	localparam int M_PS_HI = 2;

	// edge/level encodings
	localparam logic [1:0] ELS_PORT = 2'h0;
	localparam logic [1:0] ELS_TOGGLE = 2'h1;
	localparam logic [1:0] ELS_CLEAR = 2'h2;
	localparam logic [1:0] ELS_SET = 2'h3;

	// values after reset
	localparam logic [7:0] MAIN_CTL_RST = 8'h20;
	localparam logic [15:0] MOD_RST = 16'hffff;
	localparam logic [7:0] PS_ONE = 8'h01;

	// synchroniser state
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} tcc_sync_t;

	// whole state of the timer block
	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] modv;
		logic [6:0] presc;
		logic [7:0] main_ctl;
		logic ovf_armed;
		logic [7:0] lo_latch;
		logic lo_held;
		logic [1:0][7:0] ctl;
		logic [1:0] armed;
		logic [1:0][15:0] val;
		logic [1:0] cap_blk;
		logic [1:0] cmp_blk;
		logic [1:0] pin;
		logic [1:0] max_eff;
		logic [15:0] cmp_act;
		logic buf_sel;
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] wr_idx;
	} tcc_state_t;
endpackage

// [core/tcc_sync_edge.sv]
// two-flop pin synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
module tcc_sync_edge
	import tcc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic pin_in,
	output logic rise,
	output logic fall
);
	tcc_sync_t s;
	tcc_sync_t next_s;

	// s1 is seen only by s2; edges come from the settled stages
	always_comb begin
		next_s = s;
		next_s.s1 = pin_in;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rise = s.s2 & ~s.s3;
	assign fall = ~s.s2 & s.s3;
endmodule

// [core/tcc_timer.sv]
// two-channel timer: counter, capture, compare and pwm behind an ahb-lite slave
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
module tcc_timer
	import tcc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [1:0] channel_pin_in,
	output logic [1:0] channel_pin_out,
	output logic [1:0] channel_pin_oe,
	output logic [1:0] chan_irq,
	output logic overflow_irq
);
	tcc_state_t s;
	tcc_state_t next_s;

	logic [1:0] rise;
	logic [1:0] fall;
	logic acc;
	logic rd;
	logic [7:0] idx;
	logic [7:0] rdat;
	logic [7:0] wd;
	logic [6:0] pmask;
	logic tick;
	logic ovf;
	logic wr_rst;
	logic [1:0] en;
	logic [1:0] cap_mode;
	logic [1:0] cmp_mode;
	logic [1:0] match;
	logic [1:0] edge_ev;
	logic [1:0] ev;
	logic [1:0][1:0] els;
	logic [1:0][15:0] cmpv;

	// pins come from outside: two flops before the edge logic
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			tcc_sync_edge u_sync (
				.clk(clk),
				.srst(srst),
				.pin_in(channel_pin_in[g]),
				.rise(rise[g]),
				.fall(fall[g])
			);
		end
	endgenerate

	// bus decode; hsize is ignored since only whole words are used
	always_comb begin
		acc = hsel & htrans[1] & hready;
		rd = acc & ~hwrite;
		idx = (haddr[31:IDX_MSB+1] == '0) ? haddr[IDX_MSB:IDX_LSB] : IDX_NONE;
		wd = hwdata[7:0];
		wr_rst = s.wr_pend & (s.wr_idx == IDX_MAIN_CTL) & wd[M_RST];
	end

	// prescaler tap: counter steps when the low prescaler bits are all ones
	always_comb begin
		pmask = 7'((PS_ONE << s.main_ctl[M_PS_HI:0]) - PS_ONE);
		tick = ~s.main_ctl[M_STOP] & ((s.presc & pmask) == pmask);
		ovf = tick & (s.cnt == s.modv);
	end

	// per-channel mode decode, match and edge events
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			els[i] = s.ctl[i][B_ELSH:B_ELSL];
			en[i] = (i == 0) | ~s.ctl[0][B_MSB];
			cap_mode[i] = en[i] & (els[i] != ELS_PORT) & ~s.ctl[i][B_MSB] & ~s.ctl[i][B_MSA];
			cmp_mode[i] = en[i] & (els[i] != ELS_PORT) & (s.ctl[i][B_MSA] | s.ctl[i][B_MSB]);
			cmpv[i] = (s.ctl[i][B_MSB]) ? s.cmp_act : s.val[i];
			match[i] = cmp_mode[i] & tick & (s.cnt == cmpv[i]) & ~s.cmp_blk[i];
			edge_ev[i] = cap_mode[i] & ((els[i][0] & rise[i]) | (els[i][1] & fall[i]));
			ev[i] = match[i] | edge_ev[i];
		end
	end

	// read mux; unmapped registers and the channel 1 control, while disabled, read as zero
	always_comb begin
		rdat = 8'h00;
		unique case (idx)
			IDX_MAIN_CTL: rdat = s.main_ctl & ~(8'h01 << M_RST);
			IDX_CNT_HI: rdat = s.cnt[15:8];
			IDX_CNT_LO: rdat = s.lo_held ? s.lo_latch : s.cnt[7:0];
			IDX_MOD_HI: rdat = s.modv[15:8];
			IDX_MOD_LO: rdat = s.modv[7:0];
			IDX_T1C0_CTL: rdat = s.ctl[0];
			IDX_CH0_HI: rdat = s.val[0][15:8];
			IDX_CH0_LO: rdat = s.val[0][7:0];
			IDX_T1C1_CTL: rdat = en[1] ? s.ctl[1] : 8'h00;
			IDX_CH1_HI: rdat = s.val[1][15:8];
			IDX_CH1_LO: rdat = s.val[1][7:0];
			default: rdat = 8'h00;
		endcase
	end

	// next state: counter, writes, read side effects, then events last
	always_comb begin
		next_s = s;
		next_s.wr_pend = acc & hwrite;
		next_s.wr_idx = idx;
		if (rd) begin
			next_s.hrdata = {24'h000000, rdat};
		end

		// counting
		if (~s.main_ctl[M_STOP]) begin
			next_s.presc = s.presc + 7'h01;
		end
		if (tick) begin
			next_s.cnt = ovf ? 16'h0000 : s.cnt + 16'h0001;
		end

		// pin actions; overflow handled before compare so it wins
		for (int i = 0; i < 2; i++) begin
			if (els[i] == ELS_PORT) begin
				next_s.pin[i] = ~s.ctl[i][B_MSA];
			end else if (cmp_mode[i]) begin
				if (ovf & s.ctl[i][B_TOV]) begin
					next_s.pin[i] = s.max_eff[i] | ~s.pin[i];
				end else if (match[i] & ~(s.ctl[i][B_TOV] & s.max_eff[i])) begin
					unique case (els[i])
						ELS_TOGGLE: next_s.pin[i] = ~s.pin[i];
						ELS_CLEAR: next_s.pin[i] = 1'b0;
						ELS_SET: next_s.pin[i] = 1'b1;
						default: next_s.pin[i] = s.pin[i];
					endcase
				end
			end
			// max duty changes only at a period boundary
			if (ovf) begin
				next_s.max_eff[i] = s.ctl[i][B_MAX];
			end
			if (edge_ev[i] & ~s.cap_blk[i]) begin
				next_s.val[i] = s.cnt;
			end
		end

		// buffered compare picks up the last written register at overflow
		if (ovf | ~s.ctl[0][B_MSB]) begin
			next_s.cmp_act = s.buf_sel ? s.val[1] : s.val[0];
		end

		// data-phase writes
		if (s.wr_pend) begin
			unique case (s.wr_idx)
				IDX_MAIN_CTL: begin
					next_s.main_ctl[M_OIE] = wd[M_OIE];
					next_s.main_ctl[M_STOP] = wd[M_STOP];
					next_s.main_ctl[M_PS_HI:0] = wd[M_PS_HI:0];
					if (s.ovf_armed & ~wd[M_OVF]) begin
						next_s.main_ctl[M_OVF] = 1'b0;
					end
					next_s.ovf_armed = 1'b0;
					if (wd[M_RST]) begin
						next_s.cnt = 16'h0000;
						next_s.presc = 7'h00;
					end
				end
				IDX_MOD_HI: next_s.modv[15:8] = wd;
				IDX_MOD_LO: next_s.modv[7:0] = wd;
				IDX_T1C0_CTL: begin
					next_s.ctl[0][B_IE:0] = wd[B_IE:0];
					if (s.armed[0] & ~wd[B_FLAG]) begin
						next_s.ctl[0][B_FLAG] = 1'b0;
					end
					next_s.armed[0] = 1'b0;
				end
				IDX_T1C1_CTL: begin
					if (en[1]) begin
						// buffered select exists only on channel 0
						next_s.ctl[1][B_IE:0] = wd[B_IE:0] & ~(7'h01 << B_MSB);
						if (s.armed[1] & ~wd[B_FLAG]) begin
							next_s.ctl[1][B_FLAG] = 1'b0;
						end
						next_s.armed[1] = 1'b0;
					end
				end
				IDX_CH0_HI: begin
					next_s.val[0][15:8] = wd;
					next_s.cmp_blk[0] = 1'b1;
				end
				IDX_CH0_LO: begin
					next_s.val[0][7:0] = wd;
					next_s.cmp_blk[0] = 1'b0;
					next_s.buf_sel = 1'b0;
				end
				IDX_CH1_HI: begin
					next_s.val[1][15:8] = wd;
					next_s.cmp_blk[1] = 1'b1;
				end
				IDX_CH1_LO: begin
					next_s.val[1][7:0] = wd;
					next_s.cmp_blk[1] = 1'b0;
					next_s.buf_sel = 1'b1;
				end
				default: next_s.wr_idx = s.wr_idx;
			endcase
		end

		// address-phase read side effects
		if (rd) begin
			unique case (idx)
				IDX_MAIN_CTL: next_s.ovf_armed = s.main_ctl[M_OVF];
				IDX_CNT_HI: begin
					if (~s.lo_held) begin
						next_s.lo_latch = s.cnt[7:0];
						next_s.lo_held = 1'b1;
					end
				end
				IDX_CNT_LO: next_s.lo_held = 1'b0;
				IDX_T1C0_CTL: next_s.armed[0] = s.ctl[0][B_FLAG];
				IDX_T1C1_CTL: next_s.armed[1] = en[1] & s.ctl[1][B_FLAG];
				IDX_CH0_HI: next_s.cap_blk[0] = 1'b1;
				IDX_CH0_LO: next_s.cap_blk[0] = 1'b0;
				IDX_CH1_HI: next_s.cap_blk[1] = 1'b1;
				IDX_CH1_LO: next_s.cap_blk[1] = 1'b0;
				default: next_s.hrdata = next_s.hrdata;
			endcase
		end

		// events come last so a set beats a same-cycle clear
		for (int i = 0; i < 2; i++) begin
			if (ev[i]) begin
				next_s.ctl[i][B_FLAG] = 1'b1;
				next_s.armed[i] = 1'b0;
			end
		end
		if (ovf) begin
			next_s.main_ctl[M_OVF] = 1'b1;
			next_s.ovf_armed = 1'b0;
		end
	end

	// control fields, flags and counter take defined values on reset
	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
			s.main_ctl <= MAIN_CTL_RST;
			s.modv <= MOD_RST;
		end else begin
			s <= next_s;
		end
	end

	// outputs; zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign channel_pin_out = s.pin;
	assign channel_pin_oe = cmp_mode;
	assign overflow_irq = s.main_ctl[M_OVF] & s.main_ctl[M_OIE];
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			chan_irq[i] = en[i] & s.ctl[i][B_FLAG] & s.ctl[i][B_IE];
		end
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_cnt_latch_lo: assert property (
		(rd && idx == IDX_CNT_HI && !s.lo_held) |=> (s.lo_held && s.lo_latch == $past(s.cnt[7:0])))
		else $error("counter low byte not latched on high read");
	a_latch_steady: assert property (
		(rd && idx == IDX_CNT_HI && s.lo_held) |=> (s.lo_held && $stable(s.lo_latch)))
		else $error("held low byte changed by repeat high read");
	a_cnt_reset_zero: assert property (
		wr_rst |=> (s.cnt == 16'h0000))
		else $error("counter not zero after reset bit");
	a_capture_flag: assert property (
		edge_ev[1] |=> (s.ctl[1][B_FLAG] && ($past(s.cap_blk[1]) || s.val[1] == $past(s.cnt))))
		else $error("capture did not flag or store counter");
	a_compare_flag: assert property (
		match[0] |=> s.ctl[0][B_FLAG])
		else $error("compare match did not set flag");
	a_flag_clear_seq: assert property (
		$fell(s.ctl[0][B_FLAG]) |-> ($past(s.armed[0]) && $past(s.wr_pend) && !$past(ev[0])))
		else $error("flag cleared without read-then-write");
	a_flag_only_event: assert property (
		$rose(s.ctl[1][B_FLAG]) |-> $past(ev[1]))
		else $error("flag set without an event");
	a_irq_needs_both: assert property (
		$rose(chan_irq[0]) |-> (s.ctl[0][B_IE] && s.ctl[0][B_FLAG]))
		else $error("interrupt without enable and flag");
	a_ch1_disabled: assert property (
		s.ctl[0][B_MSB] |-> (!channel_pin_oe[1] && !chan_irq[1]))
		else $error("channel 1 active in buffered mode");
	a_preset_level: assert property (
		(els[0] == ELS_PORT && !$past(srst)) [*2] |-> (!channel_pin_oe[0] && s.pin[0] == !$past(s.ctl[0][B_MSA])))
		else $error("preset level wrong");
	a_ovf_wins: assert property (
		(ovf && cmp_mode[0] && s.ctl[0][B_TOV] && !s.max_eff[0]) |=> (s.pin[0] != $past(s.pin[0])))
		else $error("overflow toggle lost to compare");
	a_stop_halt: assert property (
		(s.main_ctl[M_STOP] && !s.wr_pend) |=> $stable(s.cnt))
		else $error("stopped counter moved");

	c_overflow: cover property (ovf);
	c_capture: cover property (edge_ev[1] ##[1:20] (rd && idx == IDX_CH1_HI));
	c_flag_clear: cover property ($fell(s.ctl[0][B_FLAG]));
	c_pwm_max: cover property (ovf && s.max_eff[0] && s.ctl[0][B_TOV]);
endmodule

// [verif/tcc_pin_model.sv]
// outside world of the two timer channel pins
`timescale 1ns/100ps
module tcc_pin_model
	import tcc_pkg::*;
(
	input wire logic [1:0] ext_level,
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	output logic [1:0] pin_in
);
	// block wins the wire while it drives, else the outside level shows
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// [verif/timer_channel_capture_compare_tb_top.sv]
// self-checking bench for the timer capture/compare block
`timescale 1ns/100ps
module timer_channel_capture_compare_tb_top
	import tcc_pkg::*;
;
	logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic hready, hreadyout, hresp, overflow_irq;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0, pin_in, pin_out, pin_oe, chan_irq, ext_level = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] rd, a, lows;
	int fail_count = 0, samples_checked = 0, cycles = 0;

	always #20 clk = ~clk;
	assign hready = hreadyout;

	tcc_timer DUT(.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .chan_irq(chan_irq),
		.overflow_irq(overflow_irq));
	tcc_pin_model PEER(.ext_level(ext_level), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one single transfer; the slave may stretch either phase
	task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata[7:0];
	endtask

	// read first so the following write may clear a set flag
	task cfg(input logic [7:0] idx, input logic [7:0] v);
		bus(1'b0, idx, 8'h0);
		bus(1'b1, idx, v);
	endtask

	// waits end on the falling edge so outputs are settled
	task wait_cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task wait_irq(input int ch);
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (chan_irq[ch] !== 1'b1 && k < 300);
	endtask

	task pin1(input logic v);
		@(posedge clk);
		ext_level[1] <= v;
		wait_cyc(6);
	endtask

	task t_reset;
		bus(1'b0, IDX_CNT_HI, 8'h0);
		check("cnt_hi", rd, 16'h0);
		bus(1'b0, IDX_CNT_LO, 8'h0);
		check("cnt_lo", rd, 16'h0);
		bus(1'b0, IDX_T1C0_CTL, 8'h0);
		check("ch0_ctl", rd, 16'h0);
		bus(1'b0, IDX_T1C1_CTL, 8'h0);
		check("ch1_ctl", rd, 16'h0);
		wait_cyc(1);
		check("irq_rst", chan_irq, 16'h0);
		check("preset_rst", {pin_oe, pin_out}, 16'h3);
		$display("test reset done");
	endtask

	task t_latch;
		bus(1'b1, IDX_MAIN_CTL, 8'h00);
		bus(1'b0, IDX_CNT_LO, 8'h0);
		a = rd + 8'h03; // high read is taken three edges after the low read
		bus(1'b0, IDX_CNT_HI, 8'h0);
		wait_cyc(10);
		bus(1'b0, IDX_CNT_HI, 8'h0);
		bus(1'b0, IDX_CNT_LO, 8'h0);
		check("cnt_lo_held", rd, a);
		bus(1'b1, IDX_MAIN_CTL, 8'h30);
		wait_cyc(5);
		bus(1'b0, IDX_CNT_HI, 8'h0);
		check("cnt_hi_stop", rd, 16'h0);
		bus(1'b0, IDX_CNT_LO, 8'h0);
		check("cnt_lo_stop", rd, 16'h0);
		// short period keeps the compare waits small
		bus(1'b1, IDX_MOD_HI, 8'h00);
		bus(1'b1, IDX_MOD_LO, 8'h3f);
		$display("test latch done");
	endtask

	task t_compare;
		for (int e = 1; e < 4; e++) begin
			bus(1'b1, IDX_MAIN_CTL, 8'h30);
			bus(1'b1, IDX_CH0_HI, 8'h00);
			bus(1'b1, IDX_CH0_LO, 8'h10);
			cfg(IDX_T1C0_CTL, 8'h50 | {4'h0, e[1:0], 2'h0});
			wait_cyc(2);
			a = {7'h0, pin_out[0]};
			bus(1'b1, IDX_MAIN_CTL, 8'h00);
			wait_irq(0);
			check("cmp_irq", chan_irq[0], 16'h1);
			check("cmp_oe", pin_oe[0], 16'h1);
			check("cmp_pin", pin_out[0], (e == 1) ? !a[0] : (e == 3));
			// arm the clear first so only the written one keeps the flag
			bus(1'b0, IDX_T1C0_CTL, 8'h0);
			bus(1'b1, IDX_T1C0_CTL, 8'hd0 | {4'h0, e[1:0], 2'h0});
			wait_cyc(1);
			check("flag_w1", chan_irq[0], 16'h1);
			bus(1'b1, IDX_T1C0_CTL, 8'h50 | {4'h0, e[1:0], 2'h0});
			wait_cyc(1);
			check("flag_noread", chan_irq[0], 16'h1);
			bus(1'b1, IDX_MAIN_CTL, 8'h20);
			cfg(IDX_T1C0_CTL, 8'h50 | {4'h0, e[1:0], 2'h0});
			wait_cyc(1);
			check("flag_clr", chan_irq[0], 16'h0);
		end
		// a lone high-byte write must hold off every match
		bus(1'b1, IDX_MAIN_CTL, 8'h30);
		bus(1'b1, IDX_CH0_HI, 8'h00);
		bus(1'b1, IDX_MAIN_CTL, 8'h00);
		wait_cyc(140);
		check("cmp_blocked", chan_irq[0], 16'h0);
		bus(1'b1, IDX_CH0_LO, 8'h10);
		wait_irq(0);
		check("cmp_unblocked", chan_irq[0], 16'h1);
		$display("test compare done");
	endtask

	task count_lows;
		lows = 8'h0;
		repeat (128) begin
			@(negedge clk);
			if (pin_out[0] !== 1'b1)
				lows++;
		end
	endtask

	task t_maxduty;
		bus(1'b1, IDX_MAIN_CTL, 8'h30);
		cfg(IDX_T1C0_CTL, 8'h5b);
		bus(1'b1, IDX_MAIN_CTL, 8'h00);
		wait_cyc(200);
		count_lows;
		check("max_lows", lows, 16'h0);
		cfg(IDX_T1C0_CTL, 8'h5a);
		wait_cyc(200);
		count_lows;
		check("pwm_has_low", lows != 8'h0, 16'h1);
		// stop, enable overflow irq; no status read yet so the flag survives
		bus(1'b1, IDX_MAIN_CTL, 8'h60);
		wait_cyc(1);
		check("ovf_irq", overflow_irq, 16'h1);
		bus(1'b0, IDX_MAIN_CTL, 8'h0);
		check("ovf_flag", rd[7], 16'h1);
		bus(1'b1, IDX_MAIN_CTL, 8'h60);
		wait_cyc(1);
		check("ovf_irq_clr", overflow_irq, 16'h0);
		$display("test max duty done");
	endtask

	task t_capture;
		for (int e = 1; e < 4; e++) begin
			pin1(1'b0);
			cfg(IDX_T1C1_CTL, 8'h40 | {4'h0, e[1:0], 2'h0});
			wait_cyc(1);
			check("cap_oe", pin_oe[1], 16'h0);
			pin1(1'b1);
			check("cap_rise", chan_irq[1], e != 2);
			cfg(IDX_T1C1_CTL, 8'h40 | {4'h0, e[1:0], 2'h0});
			pin1(1'b0);
			check("cap_fall", chan_irq[1], e != 1);
		end
		// a high-byte read freezes the stored value until the low read
		bus(1'b1, IDX_MAIN_CTL, 8'h30);
		bus(1'b1, IDX_MAIN_CTL, 8'h00);
		bus(1'b1, IDX_MAIN_CTL, 8'h20);
		bus(1'b0, IDX_CNT_HI, 8'h0);
		bus(1'b0, IDX_CNT_LO, 8'h0);
		a = rd; // counter parked away from zero
		pin1(1'b1);
		bus(1'b0, IDX_CH1_LO, 8'h0);
		check("cap_value", rd, a);
		bus(1'b0, IDX_CH1_HI, 8'h0);
		bus(1'b1, IDX_MAIN_CTL, 8'h30);
		pin1(1'b0);
		bus(1'b0, IDX_CH1_LO, 8'h0);
		check("cap_blocked", rd, a);
		bus(1'b1, IDX_T1C0_CTL, 8'h20);
		wait_cyc(1);
		check("buf_irq1", chan_irq[1], 16'h0);
		check("buf_oe1", pin_oe[1], 16'h0);
		bus(1'b0, IDX_T1C1_CTL, 8'h0);
		check("buf_ctl1", rd, 16'h0);
		cfg(IDX_T1C0_CTL, 8'h10);
		wait_cyc(2);
		check("preset_low", {pin_oe[0], pin_out[0]}, 16'h0);
		cfg(IDX_T1C0_CTL, 8'h00);
		wait_cyc(2);
		check("preset_high", {pin_oe[0], pin_out[0]}, 16'h1);
		// buffered compare uses the copy taken while still unbuffered
		bus(1'b1, IDX_CH0_HI, 8'h00);
		bus(1'b1, IDX_CH0_LO, 8'h20);
		cfg(IDX_T1C0_CTL, 8'h68);
		bus(1'b1, IDX_MAIN_CTL, 8'h00);
		wait_irq(0);
		check("buf_cmp_irq", chan_irq[0], 16'h1);
		check("buf_cmp_pin", {pin_oe[0], pin_out[0]}, 16'h2);
		$display("test capture done");
	endtask

	task complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// guard against a hang in any wait
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			complete_run;
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_latch;
		t_compare;
		t_maxduty;
		t_capture;
		complete_run;
	end
endmodule
